/* File: src/ceag_cfg.svh */
// Purpose: Constants for the effective address generator.
// Assumes: 8-bit data, 16-bit address bus.
// Notes: Mode codes index the mode enum in the package.
`ifndef CEAG_CFG_SVH
`define CEAG_CFG_SVH
`define CEAG_PC_RESET 16'h0000
`define CEAG_ADDR_RESET 16'h0000
`define CEAG_LEN_ONE 2'h1
`define CEAG_LEN_TWO 2'h2
`define CEAG_LEN_THREE 2'h3
`define CEAG_ZERO_PAGE_HI 8'h00
`endif

/* File: src/ceag_pkg.sv */
// Purpose: Types shared by the effective address generator.
// Assumes: Nothing beyond the config header.
// Notes: Ten addressing modes, one-hot coded.
package ceag_pkg;
  typedef enum logic [9:0] {
    CEAG_INH = 10'h001,
    CEAG_IMM = 10'h002,
    CEAG_DIR = 10'h004,
    CEAG_EXT = 10'h008,
    CEAG_IX = 10'h010,
    CEAG_IX1 = 10'h020,
    CEAG_IX2 = 10'h040,
    CEAG_REL = 10'h080,
    CEAG_BSC = 10'h100,
    CEAG_BTB = 10'h200
  } ceag_mode_t;
  typedef enum logic [3:0] {
    CEAG_S_OPC = 4'h1,
    CEAG_S_OP1 = 4'h2,
    CEAG_S_OP2 = 4'h4,
    CEAG_S_ACC = 4'h8
  } ceag_state_t;
endpackage : ceag_pkg

/* File: src/ceag_dec_if.sv */
// Purpose: Carries the decoded mode between decoder and sequencer.
// Assumes: Combinational decode.
// Notes: One producer, one consumer.
interface ceag_dec_if;
  import ceag_pkg::*;
  logic [7:0] opcode;
  ceag_mode_t mode;
  logic [1:0] length;
  logic is_jump;
  modport dec (input opcode, output mode, output length, output is_jump);
  modport seq (output opcode, input mode, input length, input is_jump);
endinterface : ceag_dec_if

/* File: src/ceag_mode_dec.sv */
// Purpose: Maps an opcode to its addressing mode and length.
// Assumes: Standard opcode map columns by high nibble.
// Notes: Pure combinational.
`include "ceag_cfg.svh"
module ceag_mode_dec
  import ceag_pkg::*;
(
  ceag_dec_if.dec d
);
  // Decode by high nibble; direct vs extended by opcode alone
  always_comb begin
    d.is_jump = (d.opcode[3:0] == 4'hc) && (d.opcode[7:4] >= 4'hb);
    unique case (d.opcode[7:4])
      4'h0: d.mode = CEAG_BTB;
      4'h1: d.mode = CEAG_BSC;
      4'h2: d.mode = CEAG_REL;
      4'h3, 4'hb: d.mode = CEAG_DIR;
      4'h4, 4'h5, 4'h8, 4'h9: d.mode = CEAG_INH;
      4'h6, 4'he: d.mode = CEAG_IX1;
      4'h7, 4'hf: d.mode = CEAG_IX;
      4'ha: d.mode = CEAG_IMM;
      4'hc: d.mode = CEAG_EXT;
      4'hd: d.mode = CEAG_IX2;
      default: d.mode = CEAG_INH;
    endcase
  end

  // Instruction length, never above three bytes
  always_comb begin
    unique case (d.mode)
      CEAG_INH, CEAG_IX: d.length = `CEAG_LEN_ONE;
      CEAG_EXT, CEAG_IX2, CEAG_BTB: d.length = `CEAG_LEN_THREE;
      default: d.length = `CEAG_LEN_TWO;
    endcase
  end
endmodule : ceag_mode_dec

/* File: src/ceag_top.sv */
// Purpose: Effective address and PC advance for a small 8-bit CPU.
// Assumes: Memory answers on rd_data in the same cycle the address is shown.
// Notes: Relative and BTB modes get PC lengths only, with targets elsewhere; BSC gets a direct operand address.
// Function
// - Inherent instructions take no operand and are one byte.
// - Immediate operand sits at PC+1; PC advances by two.
// - Direct address is zero high, operand byte low; PC plus two.
// - Extended address is first byte high, second low; PC plus three.
// - Indexed no offset uses X low, zero high; PC plus one.
// - Indexed 8-bit offset: low is X plus byte, high is carry.
// - Indexed 16-bit: low X plus second, high first plus carry.
// - Ten addressing modes selected by opcode.
// - At most three bytes; the no-offset indexed form fetches no operand.
// - Extended jump loads any address into PC.
`include "ceag_cfg.svh"
module ceag_top
  import ceag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] index_x,
  input wire logic start,
  output logic [7:0] addr_hi_q,
  output logic [7:0] addr_lo_q,
  output logic [15:0] pc_q,
  output logic [15:0] effective_address_q,
  output logic [9:0] mode_q,
  output logic operand_access_q,
  output logic done_q
);
  ceag_dec_if dif ();
  ceag_state_t state_q;
  logic [7:0] opc_q;
  logic [7:0] op1_q;
  ceag_mode_t cur_mode;
  logic [1:0] cur_len;
  logic cur_jump;
  logic [8:0] sum_x;
  logic [15:0] pc_d;
  logic done_d;

  // Sum of index and offset with carry out
  function automatic logic [8:0] ceag_add(input logic [7:0] a, input logic [7:0] b);
    ceag_add = {1'b0, a} + {1'b0, b};
  endfunction : ceag_add

  // One shared index add; a function result cannot be part-selected
  assign sum_x = ceag_add(index_x, rd_data);
  assign dif.opcode = (state_q == CEAG_S_OPC) ? rd_data : opc_q;
  assign cur_mode = dif.mode;
  assign cur_len = dif.length;
  assign cur_jump = dif.is_jump;

  ceag_mode_dec u_dec (
    .d(dif.dec)
  );

  // Fetch sequencer; one-byte forms skip operand fetch
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= CEAG_S_OPC;
      opc_q <= 8'h00;
      op1_q <= 8'h00;
    end else begin
      unique case (state_q)
        CEAG_S_OPC: begin
          if (start) begin
            opc_q <= rd_data;
            if (cur_mode == CEAG_IX) begin
              state_q <= CEAG_S_ACC;
            end else if (cur_len != `CEAG_LEN_ONE) begin
              state_q <= CEAG_S_OP1;
            end
          end
        end
        CEAG_S_OP1: begin
          op1_q <= rd_data;
          if (cur_len == `CEAG_LEN_THREE) begin
            state_q <= CEAG_S_OP2;
          end else if (cur_mode == CEAG_IMM || cur_mode == CEAG_REL) begin
            state_q <= CEAG_S_OPC;
          end else begin
            state_q <= CEAG_S_ACC;
          end
        end
        CEAG_S_OP2: begin
          state_q <= (cur_mode == CEAG_BTB || cur_jump) ? CEAG_S_OPC : CEAG_S_ACC;
        end
        CEAG_S_ACC: state_q <= CEAG_S_OPC;
        default: state_q <= CEAG_S_OPC;
      endcase
    end
  end

  // Address bus and effective address per mode
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      addr_hi_q <= 8'(`CEAG_ADDR_RESET >> 8);
      addr_lo_q <= 8'h00;
      effective_address_q <= `CEAG_ADDR_RESET;
      operand_access_q <= 1'b0;
      mode_q <= 10'h000;
    end else begin
      operand_access_q <= 1'b0;
      unique case (state_q)
        CEAG_S_OPC: begin
          if (start) begin
            mode_q <= cur_mode;
            if (cur_mode == CEAG_IX) begin
              addr_hi_q <= `CEAG_ZERO_PAGE_HI;
              addr_lo_q <= index_x;
              effective_address_q <= {`CEAG_ZERO_PAGE_HI, index_x};
              operand_access_q <= 1'b1;
            end else if (cur_len != `CEAG_LEN_ONE) begin
              {addr_hi_q, addr_lo_q} <= pc_q + 16'h0001;
              effective_address_q <= pc_q + 16'h0001;
              operand_access_q <= (cur_mode == CEAG_IMM);
            end
          end
        end
        CEAG_S_OP1: begin
          if (cur_len == `CEAG_LEN_THREE) begin
            {addr_hi_q, addr_lo_q} <= pc_q + 16'h0002;
          end else if (cur_mode == CEAG_DIR || cur_mode == CEAG_BSC) begin
            addr_hi_q <= `CEAG_ZERO_PAGE_HI;
            addr_lo_q <= rd_data;
            effective_address_q <= {`CEAG_ZERO_PAGE_HI, rd_data};
            operand_access_q <= 1'b1;
          end else if (cur_mode == CEAG_IX1) begin
            addr_hi_q <= {7'h00, sum_x[8]};
            addr_lo_q <= sum_x[7:0];
            effective_address_q <= {7'h00, sum_x};
            operand_access_q <= 1'b1;
          end
        end
        CEAG_S_OP2: begin
          if (cur_mode == CEAG_EXT) begin
            addr_hi_q <= op1_q;
            addr_lo_q <= rd_data;
            effective_address_q <= {op1_q, rd_data};
            operand_access_q <= !cur_jump;
          end else if (cur_mode == CEAG_IX2) begin
            addr_lo_q <= sum_x[7:0];
            addr_hi_q <= op1_q + {7'h00, sum_x[8]};
            effective_address_q <= {op1_q + {7'h00, sum_x[8]}, sum_x[7:0]};
            operand_access_q <= !cur_jump;
          end
        end
        default: ;
      endcase
      // Bus points at the next opcode once done, so idle rd_data is the opcode
      if (done_d) begin
        {addr_hi_q, addr_lo_q} <= pc_d;
      end
    end
  end

  // Next program counter, shared by the pc and bus processes
  always_comb begin
    pc_d = pc_q;
    done_d = 1'b0;
    unique case (state_q)
      CEAG_S_OPC: begin
        if (start && cur_len == `CEAG_LEN_ONE && cur_mode != CEAG_IX) begin
          pc_d = pc_q + 16'h0001;
          done_d = 1'b1;
        end
      end
      CEAG_S_OP1: begin
        if (cur_len == `CEAG_LEN_TWO && (cur_mode == CEAG_IMM || cur_mode == CEAG_REL)) begin
          pc_d = pc_q + 16'h0002;
          done_d = 1'b1;
        end
      end
      CEAG_S_OP2: begin
        if (cur_jump && cur_mode == CEAG_EXT) begin
          pc_d = {op1_q, rd_data};
          done_d = 1'b1;
        end else if (cur_jump && cur_mode == CEAG_IX2) begin
          pc_d = {op1_q + {7'h00, sum_x[8]}, sum_x[7:0]};
          done_d = 1'b1;
        end else if (cur_mode == CEAG_BTB) begin
          pc_d = pc_q + 16'h0003;
          done_d = 1'b1;
        end
      end
      CEAG_S_ACC: begin
        pc_d = pc_q + {14'h0000, cur_len};
        done_d = 1'b1;
      end
      default: begin
        pc_d = pc_q;
        done_d = 1'b0;
      end
    endcase
  end

  // Program counter advance; extended jump reaches whole map
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pc_q <= `CEAG_PC_RESET;
      done_q <= 1'b0;
    end else begin
      pc_q <= pc_d;
      done_q <= done_d;
    end
  end
endmodule : ceag_top

/* File: test/ceag_top_sva.sv */
// Purpose: Port checks for the address generator.
// Assumes: One clock, resetn active low.
// Notes: Bound from the bench top file.
module ceag_top_sva
  import ceag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] index_x,
  input wire logic [7:0] addr_hi_q,
  input wire logic [7:0] addr_lo_q,
  input wire logic [15:0] pc_q,
  input wire logic [9:0] mode_q,
  input wire logic operand_access_q,
  input wire logic done_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Mode and handshake shape
  property p_hot; $onehot0(mode_q); endproperty
  a_hot: assert property (p_hot) else $error("mode not one-hot");
  property p_acc; operand_access_q |=> done_q && !operand_access_q; endproperty
  a_acc: assert property (p_acc) else $error("no done after access");
  property p_pulse; done_q |=> !done_q; endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  property p_pc; $changed(pc_q) |-> done_q; endproperty
  a_pc: assert property (p_pc) else $error("pc moved early");
  // Address bus at the operand access
  property p_dir; operand_access_q && mode_q == CEAG_DIR |-> addr_hi_q == 8'h00; endproperty
  a_dir: assert property (p_dir) else $error("direct high");
  property p_ix;
    operand_access_q && mode_q == CEAG_IX |-> {addr_hi_q, addr_lo_q} == {8'h00, index_x};
  endproperty
  a_ix: assert property (p_ix) else $error("indexed address");
  property p_ix1; operand_access_q && mode_q == CEAG_IX1 |-> addr_hi_q[7:1] == 7'h00; endproperty
  a_ix1: assert property (p_ix1) else $error("offset high");
  // Program counter advance
  property p_inh; done_q && mode_q == CEAG_INH |-> pc_q == $past(pc_q) + 16'h0001; endproperty
  a_inh: assert property (p_inh) else $error("inherent length");
  property p_two;
    done_q && mode_q inside {CEAG_IMM, CEAG_DIR, CEAG_IX1} |-> pc_q == $past(pc_q) + 16'h0002;
  endproperty
  a_two: assert property (p_two) else $error("two byte length");
  c_ext: cover property (operand_access_q && mode_q == CEAG_EXT);
  c_carry: cover property (operand_access_q && addr_hi_q == 8'h01);
  c_inh: cover property (done_q && mode_q == CEAG_INH);
endmodule : ceag_top_sva

/* File: test/ceag_mem_model.sv */
// Purpose: Memory behind the address bus.
// Assumes: Read answers in the cycle the address is shown.
// Notes: Filled with a pattern so no read is unknown.
module ceag_mem_model (
  input wire logic clk_sys,
  input wire logic [7:0] addr_hi_q,
  input wire logic [7:0] addr_lo_q,
  output logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  // Pattern fill avoids stale-value matches
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5a;
  end
  // Asynchronous read; the design samples the byte at the next edge
  assign rd_data = mem[{addr_hi_q, addr_lo_q}];
endmodule : ceag_mem_model

/* File: test/ceag_top_tb.sv */
// Purpose: Self-checking bench for the address generator.
// Assumes: Idle bus shows pc_q, so rd_data holds the opcode.
// Notes: Expected pc tracked here, never read back.
module ceag_top_tb;
  import ceag_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, resetn, start, operand_access_q, done_q;
  logic [7:0] rd_data, index_x, addr_hi_q, addr_lo_q;
  logic [15:0] pc_q, effective_address_q, pc_e, seen_a;
  logic [9:0] mode_q;
  int mismatches, checked;
  ceag_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .rd_data(rd_data), .index_x(index_x),
    .start(start), .addr_hi_q(addr_hi_q), .addr_lo_q(addr_lo_q), .pc_q(pc_q),
    .effective_address_q(effective_address_q), .mode_q(mode_q),
    .operand_access_q(operand_access_q), .done_q(done_q));
  ceag_mem_model u_mem (.clk_sys(clk_sys), .addr_hi_q(addr_hi_q), .addr_lo_q(addr_lo_q),
    .rd_data(rd_data));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // One instruction: load bytes, start, bounded wait for done
  task automatic exec(input logic [7:0] opc, b1, b2, x, input logic [9:0] md,
      input logic [15:0] npc, input logic chk, input logic [15:0] ea);
    u_mem.mem[pc_e] = opc;
    u_mem.mem[pc_e + 16'h1] = b1;
    u_mem.mem[pc_e + 16'h2] = b2;
    index_x = x;
    seen_a = 16'hdead;
    repeat (2) @(posedge clk_sys);
    #1 start = 1'b1;
    @(posedge clk_sys);
    #1 start = 1'b0;
    for (int n = 0; n < 8 && done_q !== 1'b1; n++) begin
      if (operand_access_q === 1'b1) seen_a = {addr_hi_q, addr_lo_q};
      @(posedge clk_sys);
      #1;
    end
    if (done_q !== 1'b1) begin
      mismatches++;
      complete_run();
    end
    check(pc_q, npc);
    check({6'h00, mode_q}, {6'h00, md});
    if (chk) check(seen_a, ea);
    if (chk) check(effective_address_q, ea);
    pc_e = npc;
  endtask : exec
  // Short forms, no operand fetch for one-byte ones
  task automatic t_short;
    exec(8'h4c, 8'h00, 8'h00, 8'h00, CEAG_INH, pc_e + 16'h1, 1'b0, 16'h0);
    exec(8'ha6, 8'h55, 8'h00, 8'h00, CEAG_IMM, pc_e + 16'h2, 1'b0, 16'h0);
    exec(8'hf6, 8'h00, 8'h00, 8'h9a, CEAG_IX, pc_e + 16'h1, 1'b1, 16'h009a);
  endtask : t_short
  // Page zero forms, carry at the top of the offset range
  task automatic t_page;
    exec(8'hb6, 8'hc5, 8'h00, 8'h00, CEAG_DIR, pc_e + 16'h2, 1'b1, 16'h00c5);
    exec(8'he6, 8'hff, 8'h00, 8'hff, CEAG_IX1, pc_e + 16'h2, 1'b1, 16'h01fe);
  endtask : t_page
  // Three-byte forms and a far jump
  task automatic t_long;
    exec(8'hc6, 8'h12, 8'h34, 8'h00, CEAG_EXT, pc_e + 16'h3, 1'b1, 16'h1234);
    exec(8'hd6, 8'h12, 8'hf0, 8'h20, CEAG_IX2, pc_e + 16'h3, 1'b1, 16'h1310);
    exec(8'hcc, 8'hab, 8'hcd, 8'h00, CEAG_EXT, 16'habcd, 1'b0, 16'h0);
  endtask : t_long
  // Remaining modes by length only
  task automatic t_bits;
    exec(8'h20, 8'h04, 8'h00, 8'h00, CEAG_REL, pc_e + 16'h2, 1'b0, 16'h0);
    exec(8'h10, 8'h40, 8'h00, 8'h00, CEAG_BSC, pc_e + 16'h2, 1'b0, 16'h0);
    exec(8'h00, 8'h40, 8'h02, 8'h00, CEAG_BTB, pc_e + 16'h3, 1'b0, 16'h0);
  endtask : t_bits
  initial begin
    resetn = 1'b0;
    start = 1'b0;
    index_x = 8'h00;
    pc_e = 16'h0000;
    repeat (12) @(posedge clk_sys);
    #1 resetn = 1'b1;
    t_short();
    t_page();
    t_long();
    t_bits();
    complete_run();
  end
endmodule : ceag_top_tb
bind ceag_top ceag_top_sva u_sva (.clk_sys(clk_sys), .resetn(resetn), .index_x(index_x),
  .addr_hi_q(addr_hi_q), .addr_lo_q(addr_lo_q), .pc_q(pc_q), .mode_q(mode_q),
  .operand_access_q(operand_access_q), .done_q(done_q));
